// [logic/ddc_nco_mixer_halfband.sv]
// quadrature oscillator, first mixer, half-band decimator, second mixer, word serializer
// assumes samples arrive on i_clk from the converter core, one per cycle at most
//
// Summary of operation
// - 32-bit tuning word over four byte locations
// - step is sample rate over two^32
// - cosine feeds in-phase, sine feeds quadrature
// - separate 16-bit phase offset per channel
// - offset code maps linearly onto full turn
// - mixer outputs sample times cos and sin
// - two bits enable amplitude and phase dither
// - spurious range above 116 and 112 dB
// - complex output may be decimated further outside
// - real mode re-centres at quarter rate, doubles
// - second mixer after filters single, before dual
// - real shift scales with extra decimation ratio
// - in-phase word on word clock, quadrature follows
// - dual order: ch0 I, Q, ch1 I, Q
// - half-band filter decimates by two
// - control bits pick high or low pass
// - stopband and ripple figures of half-band
// - half-band adds 80 cycles of latency
// - filter output to second mixer or onward
// - total decimation is twice the FIR setting
// - select bit enables filter with decimation
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module ddc_nco_mixer_halfband (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	// register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	// sample streams
	input  ddc_pkg::sample_s i_sample,
	input  ddc_pkg::iq_s     i_fir_return,
	output ddc_pkg::iq_s     o_iq,
	output ddc_pkg::word_s   o_word
);
	import ddc_pkg::*;

	localparam logic [255:0] ATAN = `CORDIC_ATAN;

	state_s     st;
	state_s     next;
	logic       mix1_on;
	logic       real_on;
	logic       hb_en;
	logic       hb_hp;
	logic       nco_on;
	logic       adith_on;
	logic       pdith_on;
	logic       dual_on;
	logic       mix2_sel;
	logic       real_sel;
	logic [1:0] tidx;
	logic [3:0] pidx;
	logic       in_tune;
	logic       in_phase;
	logic [31:0] phase_full;
	angle_t     ang;
	iq_t        xs;
	iq_t        xp;
	iq_s        mix;
	iq_s        hb_res;
	iq_s        src;
	logic       hc;
	logic       sc;

	// control decode; fields come from software-written bytes, mix2_sel also gated off in dual mode
	assign mix1_on  = st.ctrl[`BIT_MIX1];
	assign real_on  = st.ctrl[`BIT_REAL];
	assign hb_en    = st.ctrl[`BIT_HB_EN];
	assign hb_hp    = st.ctrl[`BIT_HB_HP];
	assign nco_on   = st.ctrl[`BIT_NCO];
	assign adith_on = st.ctrl[`BIT_ADITH];
	assign pdith_on = st.ctrl[`BIT_PDITH];
	assign dual_on  = st.mode[`BIT_DUAL];
	assign mix2_sel = st.mode[`BIT_MIX2] & ~dual_on;
	assign real_sel = real_on | mix2_sel;
	assign tidx     = 2'(i_addr - `ADDR_TUNE0);
	assign pidx     = 4'(i_addr - `ADDR_PHASE0);
	assign in_tune  = (i_addr >= `ADDR_TUNE0) && (i_addr <= `ADDR_TUNE3);
	assign in_phase = (i_addr >= `ADDR_PHASE0) && (i_addr <= `ADDR_PHASE_LAST);

	// symmetric 7-tap half-band; high-pass flips the sign of the near taps
	function automatic iq_t hb_filt(input iq_t a0, input iq_t a2, input iq_t a3,
		input iq_t a4, input iq_t a6, input logic hp);
		logic signed [23:0] near;
		logic signed [23:0] sum;
		near = `HB_NEAR * (24'(a2) + 24'(a4));
		sum  = `HB_CENTER * 24'(a3) + (hp ? -near : near) - `HB_FAR * (24'(a0) + 24'(a6));
		return sum[17+`HB_SHIFT:`HB_SHIFT];
	endfunction

	//==========================================================================
	// next-state logic
	//==========================================================================
	always_comb
	begin
		next       = st;
		phase_full = '0;
		ang        = '0;
		xs         = '0;
		xp         = '0;
		mix        = '0;
		hb_res     = '0;
		src        = '0;
		hc         = '0;
		sc         = '0;

		// writes: multi-byte values commit only on their top byte
		if (i_wr)
		begin
			case (i_addr)
				`ADDR_CTRL: next.ctrl = i_wdata;
				`ADDR_MODE: next.mode = i_wdata;
				`ADDR_TUNE3: next.tune = {i_wdata, st.tune_stage};
				default:
				begin
					if (in_tune)
						next.tune_stage[{tidx, 3'b000} +: 8] = i_wdata;
					else if (in_phase && !pidx[0])
						next.phase_lo = i_wdata;
					else if (in_phase)
						next.phase[pidx[3:1]] = {i_wdata, st.phase_lo};
				end
			endcase
		end

		// reads: data shows the cycle after the strobe only
		next.rdata = '0;
		if (i_rd)
		begin
			case (i_addr)
				`ADDR_CTRL: next.rdata = st.ctrl;
				`ADDR_MODE: next.rdata = st.mode;
				`ADDR_STATUS: next.rdata = st.acc[31:24];
				default:
				begin
					if (in_tune)
						next.rdata = st.tune[{tidx, 3'b000} +: 8];
					else if (in_phase && pidx[0])
						next.rdata = st.phase[pidx[3:1]][15:8];
					else if (in_phase)
						next.rdata = st.phase[pidx[3:1]][7:0];
				end
			endcase
		end

		// accumulator steps once per sampling instant, on channel 0
		// the frozen accumulator when off keeps unused modes quiet
		next.in_reg = i_sample;
		if (i_sample.valid && i_sample.channel == '0 && nco_on)
			next.acc = st.acc + st.tune;
		next.lfsr = {st.lfsr[14:0], ^(st.lfsr & `LFSR_TAPS)};

		// phase dither spreads the truncation error below the table bits
		phase_full = st.acc + (pdith_on ? {16'h0000, st.lfsr} : 32'h0000_0000);
		ang = phase_full[31:16] + st.phase[st.in_reg.channel];

		// amplitude dither adds a random lsb to the sample; prescale cancels rotator gain
		xs = {{2{st.in_reg.data[15]}}, st.in_reg.data};
		xs = xs + $signed({17'b0, adith_on & st.lfsr[15]});
		xp = (xs >>> 1) + (xs >>> 3) - (xs >>> 6) - (xs >>> 9);

		// rotating (x,0) by the phase yields x*cos and x*sin at once
		next.cord[0].valid   = st.in_reg.valid;
		next.cord[0].channel = st.in_reg.channel;
		next.cord[0].y       = '0;
		if (ang[15] ^ ang[14])
		begin
			next.cord[0].x = -xp;
			next.cord[0].z = ang ^ `HALF_TURN;
		end
		else
		begin
			next.cord[0].x = xp;
			next.cord[0].z = ang;
		end
		for (int s = 0; s < `CORDIC_STAGES; s++)
		begin
			next.cord[s+1].valid   = st.cord[s].valid;
			next.cord[s+1].channel = st.cord[s].channel;
			if (st.cord[s].z[15])
			begin
				next.cord[s+1].x = st.cord[s].x + (st.cord[s].y >>> s);
				next.cord[s+1].y = st.cord[s].y - (st.cord[s].x >>> s);
				next.cord[s+1].z = st.cord[s].z + ATAN[s*16 +: 16];
			end
			else
			begin
				next.cord[s+1].x = st.cord[s].x - (st.cord[s].y >>> s);
				next.cord[s+1].y = st.cord[s].y + (st.cord[s].x >>> s);
				next.cord[s+1].z = st.cord[s].z - ATAN[s*16 +: 16];
			end
		end

		// first mixer output, or the raw sample when the mixer is off
		if (mix1_on)
		begin
			mix.valid   = st.cord[`CORDIC_STAGES].valid;
			mix.channel = st.cord[`CORDIC_STAGES].channel;
			mix.i       = st.cord[`CORDIC_STAGES].x;
			mix.q       = st.cord[`CORDIC_STAGES].y;
		end
		else
		begin
			mix.valid   = st.in_reg.valid;
			mix.channel = st.in_reg.channel;
			mix.i       = xs;
			mix.q       = '0;
		end

		// half-band: per-channel history, output on every second sample
		// pair parity runs on while bypassed, so enabling mid-stream keeps alignment
		hc = mix.channel[0];
		next.dly = {st.dly[`HB_LATENCY-2:0], iq_s'('0)};
		if (mix.valid)
		begin
			next.hist[hc]  = {st.hist[hc][`HB_TAPS-3:0], {mix.i, mix.q}};
			next.decim[hc] = ~st.decim[hc];
			if (st.decim[hc])
			begin
				next.dly[0].valid   = 1'b1;
				next.dly[0].channel = mix.channel;
				next.dly[0].i = hb_filt(mix.i, st.hist[hc][1].i, st.hist[hc][2].i,
					st.hist[hc][3].i, st.hist[hc][5].i, hb_hp);
				next.dly[0].q = hb_filt(mix.q, st.hist[hc][1].q, st.hist[hc][2].q,
					st.hist[hc][3].q, st.hist[hc][5].q, hb_hp);
			end
		end
		// the delay line pads the filter out to its fixed latency
		hb_res = hb_en ? st.dly[`HB_LATENCY-1] : mix;
		next.iq_out = hb_res;

		// second mixer: decimated return stream in single mode, else filter output
		src = mix2_sel ? i_fir_return : hb_res;
		sc  = src.channel[0];
		if (src.valid)
		begin
			next.word.valid = 1'b1;
			next.word.frame = (src.channel == '0);
			next.pend_v     = 1'b1;
			if (real_sel)
			begin
				// quarter-rate rotation of the interleaved stream, two words per pair
				next.flip[sc]  = ~st.flip[sc];
				next.word.data = st.flip[sc] ? -src.i : src.i;
				next.pend      = st.flip[sc] ? src.q : -src.q;
			end
			else
			begin
				next.word.data = src.i;
				next.pend      = src.q;
			end
		end
		else if (st.pend_v)
		begin
			// a new pair overrides a pending word; pairs on back-to-back cycles lose their Q word
			next.word.valid = 1'b1;
			next.word.frame = 1'b0;
			next.word.data  = st.pend;
			next.pend_v     = 1'b0;
		end
		else
		begin
			next.word.valid = 1'b0;
			next.word.frame = 1'b0;
		end
	end

	//==========================================================================
	// state register
	//==========================================================================
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st      <= '0;
			st.ctrl <= `CTRL_RESET;
			st.mode <= `MODE_RESET;
			st.tune <= `TUNE_RESET;
			st.lfsr <= `LFSR_SEED;
		end
		else
		begin
			st <= next;
		end
	end

	// outputs straight from flip-flops
	assign o_rdata = st.rdata;
	assign o_iq    = st.iq_out;
	assign o_word  = st.word;

	//==========================================================================
	// assertions
	//==========================================================================
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_pair_done;
		mix.valid && hb_en && st.decim[mix.channel[0]];
	endsequence

	sequence s_lone_pair;
		(src.valid && !real_sel) ##1 !src.valid;
	endsequence

	sequence s_real_even;
		(src.valid && real_sel && !st.flip[sc]) ##1 !src.valid;
	endsequence

	chk_tune_commit: assert property (
		i_wr && i_addr == `ADDR_TUNE3 |=> st.tune == {$past(i_wdata), $past(st.tune_stage)})
		else $error("tuning word not committed on top byte");

	// stage bytes below the top one leave the running word alone
	chk_tune_stage: assert property (
		i_wr && in_tune && i_addr != `ADDR_TUNE3 |=> $stable(st.tune))
		else $error("staged tuning byte disturbed running word");

	chk_acc_step: assert property (
		i_sample.valid && i_sample.channel == '0 && nco_on
		|=> st.acc == $past(st.acc) + $past(st.tune))
		else $error("accumulator did not step by tuning word");

	chk_acc_hold: assert property (
		!nco_on |=> st.acc == $past(st.acc))
		else $error("accumulator moved while oscillator off");

	chk_phase_commit: assert property (
		i_wr && in_phase && pidx[0]
		|=> st.phase[$past(pidx[3:1])] == {$past(i_wdata), $past(st.phase_lo)})
		else $error("phase offset not committed");

	chk_mixer_depth: assert property (
		st.in_reg.valid |-> ##17 st.cord[`CORDIC_STAGES].valid)
		else $error("rotator pipeline lost a sample");

	chk_hb_latency: assert property (
		s_pair_done |-> ##80 (hb_res.valid && hb_res.channel == $past(mix.channel, 80)))
		else $error("half-band latency is not 80 cycles");

	chk_hb_decim: assert property (
		hb_en && !dual_on && hb_res.valid |=> !hb_res.valid)
		else $error("half-band output faster than half rate");

	chk_read_ctrl: assert property (
		i_rd && i_addr == `ADDR_CTRL |=> o_rdata == $past(st.ctrl))
		else $error("control read-back wrong");

	chk_word_pair: assert property (
		s_lone_pair |-> (o_word.data == $past(src.i) && o_word.valid)
		##1 (o_word.data == $past(src.q, 2) && o_word.valid && !o_word.frame))
		else $error("complex words not I then Q");

	chk_frame_chan: assert property (
		o_word.frame |-> o_word.valid && $past(src.valid) && $past(src.channel) == '0)
		else $error("word clock not on channel 0 first word");

	chk_real_signs: assert property (
		s_real_even |-> (o_word.data == $past(src.i) && o_word.valid)
		##1 (o_word.data == -$past(src.q, 2) && o_word.valid))
		else $error("real-mode pair signs wrong");
endmodule

// [logic/ddc_map.svh]
// register offsets, field positions, reset values and datapath figures
// assumes inclusion by ddc_pkg and the front-end module only
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH
// byte offsets on the register port
`define ADDR_CTRL       8'h80
`define ADDR_MODE       8'h81
`define ADDR_TUNE0      8'h82
`define ADDR_TUNE3      8'h85
`define ADDR_PHASE0     8'h86
`define ADDR_PHASE_LAST 8'h95
`define ADDR_STATUS     8'h96
// control register fields
`define BIT_MIX1        0
`define BIT_REAL        1
`define BIT_HB_EN       2
`define BIT_HB_HP       3
`define BIT_NCO         5
`define BIT_ADITH       6
`define BIT_PDITH       7
// mode register fields
`define BIT_DUAL        0
`define BIT_MIX2        6
// reset values
`define CTRL_RESET      8'h00
`define MODE_RESET      8'h00
`define TUNE_RESET      32'h0000_0000
`define LFSR_SEED       16'hACE1
`define LFSR_TAPS       16'hB400
// datapath figures
`define PHASE_CH        8
`define HALF_TURN       16'h8000
`define CORDIC_STAGES   16
`define CORDIC_ATAN     {16'h0000, 16'h0001, 16'h0001, 16'h0003, 16'h0005, 16'h000A, \
                         16'h0014, 16'h0029, 16'h0051, 16'h00A3, 16'h0146, 16'h028B, \
                         16'h0511, 16'h09FB, 16'h12E4, 16'h2000}
`define HB_TAPS         7
`define HB_LATENCY      80
`define HB_CENTER       24'sh10
`define HB_NEAR         24'sh09
`define HB_FAR          24'sh01
`define HB_SHIFT        5
`endif

// [logic/ddc_pkg.sv]
// types shared by the down-converter front end
// assumes ddc_map.svh on the include path
`include "ddc_map.svh"
package ddc_pkg;
	typedef logic signed [15:0] sample_t;
	typedef logic signed [17:0] iq_t;
	typedef logic [15:0]        angle_t;
	typedef struct packed {logic valid; logic [2:0] channel; sample_t data;} sample_s;
	typedef struct packed {logic valid; logic [2:0] channel; iq_t i; iq_t q;} iq_s;
	typedef struct packed {logic valid; logic frame; iq_t data;} word_s;
	typedef struct packed {logic valid; logic [2:0] channel; iq_t x; iq_t y; angle_t z;} cordic_s;
	typedef struct packed {iq_t i; iq_t q;} pair_s;
	typedef struct packed {
		logic [7:0]                        ctrl;
		logic [7:0]                        mode;
		logic [23:0]                       tune_stage;
		logic [31:0]                       tune;
		logic [7:0]                        phase_lo;
		logic [`PHASE_CH-1:0][15:0]        phase;
		logic [31:0]                       acc;
		logic [15:0]                       lfsr;
		sample_s                           in_reg;
		cordic_s [`CORDIC_STAGES:0]        cord;
		pair_s [1:0][`HB_TAPS-2:0]         hist;
		logic [1:0]                        decim;
		iq_s [`HB_LATENCY-1:0]             dly;
		logic [1:0]                        flip;
		iq_s                               iq_out;
		word_s                             word;
		iq_t                               pend;
		logic                              pend_v;
		logic [7:0]                        rdata;
	} state_s;
endpackage

// [verification/adc_partner.sv]
// converter-core sample source and far decimator loop-back
// assumes ddc_pkg compiled first and the bench steering run, gap and level
`timescale 1ns/1ns
module adc_partner (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	// stream control
	input  wire logic             i_run,
	input  wire logic             i_dual,
	input  wire logic [3:0]       i_gap,
	input  wire ddc_pkg::sample_t i_level,
	// streams
	input  ddc_pkg::iq_s          i_iq,
	output ddc_pkg::sample_s      o_sample,
	output ddc_pkg::iq_s          o_fir_return
);
	import ddc_pkg::*;
	logic [3:0] idle_left;
	logic       odd_ch;
	// ==========
	// one sample a cycle at most, channel 1 carries the negated level
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_sample     <= '0;
			o_fir_return <= '0;
			idle_left    <= 4'h0;
			odd_ch       <= 1'b0;
		end
		else
		begin
			// far decimator stands in as a plain one-cycle pass
			o_fir_return     <= i_iq;
			o_sample.valid   <= 1'b0;
			o_sample.channel <= 3'h0;
			// idle bus shows the inverse so stale data never passes
			o_sample.data    <= ~i_level;
			if (!i_run)
				odd_ch <= 1'b0;
			if (idle_left != 4'h0)
				idle_left <= idle_left - 4'h1;
			else if (i_run)
			begin
				o_sample.valid   <= 1'b1;
				o_sample.channel <= {2'b00, odd_ch};
				o_sample.data    <= odd_ch ? -i_level : i_level;
				odd_ch           <= i_dual & ~odd_ch;
				idle_left        <= i_gap;
			end
		end
	end
endmodule

// [verification/testbench.sv]
// self-checking bench: register tasks and stream scenarios
// assumes ddc_pkg and the front end compiled first, one 125 MHz clock
`timescale 1ns/1ns
module testbench;
	import ddc_pkg::*;
	logic       i_clk = 1'b0;
	logic       i_arst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic [7:0] o_rdata;
	sample_s    i_sample;
	iq_s        i_fir_return;
	iq_s        o_iq;
	word_s      o_word;
	logic       run = 1'b0;
	logic       clr = 1'b0;
	logic       dual = 1'b0;
	logic [3:0] gap = 4'h0;
	sample_t    level = 16'sh1F40;
	int         failures = 0;
	int         n_compared = 0;
	int         cyc = 0;
	int         n_in, n_out, n_w, t_in1, t_in2, t_out, lat_off, tot;
	iq_t        cap_i, cap_q, last_i, lp_i;
	iq_t        w_d [16];
	logic       w_f [16];
	logic [7:0] rv;

	always #4 i_clk = ~i_clk;

	ddc_nco_mixer_halfband DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_sample(i_sample), .i_fir_return(i_fir_return), .o_iq(o_iq), .o_word(o_word));
	adc_partner far_end (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_run(run), .i_dual(dual),
		.i_gap(gap), .i_level(level), .i_iq(o_iq), .o_sample(i_sample),
		.o_fir_return(i_fir_return));

	// ==========
	// stream bookkeeping; a hang ends the run through the verdict
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (i_sample.valid)
		begin
			n_in <= n_in + 1;
			if (n_in == 0) t_in1 <= cyc;
			if (n_in == 1) t_in2 <= cyc;
		end
		if (o_iq.valid)
		begin
			n_out <= n_out + 1;
			last_i <= o_iq.i;
			if (n_out == 0) {t_out, cap_i, cap_q} <= {cyc, o_iq.i, o_iq.q};
		end
		if (o_word.valid && n_w < 16) {w_d[n_w], w_f[n_w]} <= {o_word.data, o_word.frame};
		if (o_word.valid) n_w <= n_w + 1;
		// clearing last so it wins over any count in the same cycle
		if (clr)
		begin
			n_in  <= 0;
			n_out <= 0;
			n_w   <= 0;
		end
		if (cyc == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	// ==========
	// register port and comparison tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		{i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		{i_addr, i_rd} <= {a, 1'b1};
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rv = o_rdata;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// counters are cleared only while the stream is drained
	task automatic stream(input int n);
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		run <= 1'b1;
		@(posedge i_clk);
		while (n_in < n) @(posedge i_clk);
		run <= 1'b0;
		repeat (150) @(posedge i_clk);
	endtask
	task automatic give_verdict;
		$display("compared %0d, wrong %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// axis and sign of the dominant mixer component
	function automatic logic [2:0] quad(input iq_t i, input iq_t q);
		int ai;
		int aq;
		ai = (i < 0) ? -i : i;
		aq = (q < 0) ? -q : q;
		if (ai > 8 * aq) return (i < 0) ? 3'd2 : 3'd0;
		if (aq > 8 * ai) return (q < 0) ? 3'd3 : 3'd1;
		return 3'd4;
	endfunction
	function automatic logic [1:0] sgn(input iq_t v);
		return (v == 0) ? 2'd0 : (v < 0) ? 2'd2 : 2'd1;
	endfunction
	function automatic int mag(input iq_t v);
		return (v < 0) ? -v : v;
	endfunction

	// ==========
	// scenarios
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(8'h80);
		check(rv, 8'h00);
		wr(8'h80, 8'hDB);
		rd(8'h80);
		check(rv, 8'hDB);
		wr(8'h7F, 8'h55);
		rd(8'h7F);
		check(rv, 8'h00);
		$display("test registers finished");
		// quarter turns of channel 0 offset, oscillator held still
		gap <= 4'h3;
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h86, 8'h00);
			wr(8'h87, 8'(k * 64));
			wr(8'h80, 8'h01);
			stream(3);
			check(quad(cap_i, cap_q), k);
		end
		$display("test mixer finished");
		// step of a quarter turn per sample shows in the top byte
		wr(8'h82, 8'h00);
		wr(8'h83, 8'h00);
		wr(8'h84, 8'h00);
		wr(8'h85, 8'h40);
		wr(8'h80, 8'hE1);
		stream(5);
		tot = n_in;
		rd(8'h96);
		check(rv, (tot * 64) % 256);
		// staged low bytes must not disturb the running word
		// an even sample total so far keeps the half-band pairs in step
		wr(8'h82, 8'hFF);
		wr(8'h83, 8'hFF);
		wr(8'h84, 8'hFF);
		stream(5);
		tot += n_in;
		rd(8'h96);
		check(rv, (tot * 64) % 256);
		$display("test oscillator finished");
		// oscillator and mixer both off; half-band latency, rate and high-pass checks
		gap <= 4'h0;
		wr(8'h80, 8'h00);
		stream(40);
		check(n_out, n_in);
		lat_off = t_out - t_in1;
		wr(8'h80, 8'h04);
		stream(40);
		check(t_out - t_in2 - lat_off, 80);
		check(n_out, n_in / 2);
		lp_i = last_i;
		wr(8'h80, 8'h0C);
		stream(40);
		check(mag(lp_i) > 4 * mag(last_i), 1);
		$display("test half-band finished");
		// dual complex words spaced so none is overrun
		wr(8'h81, 8'h01);
		dual <= 1'b1;
		gap <= 4'h5;
		wr(8'h80, 8'h00);
		stream(4);
		for (int k = 0; k < 4; k++)
		begin
			check(w_f[k], k == 0);
			check(sgn(w_d[k]), (k == 0) ? 1 : (k == 2) ? 2 : 0);
		end
		wr(8'h81, 8'h00);
		dual <= 1'b0;
		gap <= 4'h0;
		$display("test word order finished");
		// real mode flips the in-phase sign on alternate pairs
		wr(8'h80, 8'h06);
		stream(40);
		check(sgn(w_d[9]), 0);
		check(sgn(w_d[8]) ^ sgn(w_d[10]), 3);
		$display("test real mode finished");
		// second mixer on the looped-back stream, single channel only
		wr(8'h81, 8'h40);
		wr(8'h80, 8'h04);
		stream(40);
		check(n_w, n_in);
		check(sgn(w_d[8]) ^ sgn(w_d[10]), 3);
		wr(8'h81, 8'h00);
		$display("test second mixer finished");
		give_verdict();
	end
endmodule
